// >>> mcu_model.sv
`timescale 1ns/1ps
module mcu_model (
  // Clock and interrupt line.
  input wire logic mclk_i,
  input wire logic irq_n_i,
  // Interrupt request back to the supervisor.
  output logic irq_req_o = 1'b0
);
  // The core answers an asserted interrupt line one clock later.
  always_ff @(posedge mclk_i) begin
    irq_req_o <= !irq_n_i;
  end
endmodule : mcu_model

// >>> pos_props.sv
`timescale 1ns/1ps
module pos_props
  import power_output_supervisor_pkg::*;
#(
  parameter int unsigned WD_FAST_CYCLES = 20,
  parameter int unsigned WD_SLOW_CYCLES = 40
) (
  // Clock, reset and bus handshakes.
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Faults and system lines.
  input wire power_output_supervisor_pkg::fault_in_t faults_i,
  input wire logic cpu_irq_request_i,
  input wire power_output_supervisor_pkg::power_out_t power_o,
  input wire power_output_supervisor_pkg::power_mode_t power_mode_o,
  input wire logic watchdog_osc_enable_o,
  input wire logic main_regulator_on_o,
  input wire logic system_reset_o,
  input wire logic irq_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_VOLT_HS: assert property (ce_i && (faults_i.low_voltage || faults_i.high_voltage)
    |=> !power_o.high_side_output) else $error("high side on in voltage fault");
  AST_OC_HS: assert property (ce_i && faults_i.high_side_oc
    |=> !power_o.high_side_output) else $error("high side on in overcurrent");
  AST_OC_SS: assert property (ce_i && faults_i.switched_supply_oc
    |=> !power_o.switched_supply_output) else $error("switched supply on after overcurrent");
  AST_OC_BR: assert property (ce_i && faults_i.bridge_oc |=> !power_o.bridges_enable)
    else $error("bridges on after overcurrent");
  AST_PS_GATE: assert property (!power_o.lin_tx_enable |-> power_o[5:1] == 5'h00)
    else $error("output on with power stages off");
  AST_IRQ_RUN: assert property (ce_i && cpu_irq_request_i
    |=> ##[0:1] power_mode_o == mode_run) else $error("stop kept after interrupt request");
  AST_RST_QUIET: assert property ($fell(rst_i)
    |-> !watchdog_osc_enable_o && irq_n_o && !system_reset_o) else $error("not quiet");
  AST_WD_RUN: assert property (system_reset_o |-> power_mode_o == mode_run)
    else $error("system reset in stop mode");
  AST_WAKE_REG: assert property ($fell(irq_n_o) |-> main_regulator_on_o)
    else $error("wake without regulator");
  cover property (s_axi_bvalid_o && s_axi_bready_i);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
  cover property ($fell(irq_n_o));
  cover property (system_reset_o);
endmodule : pos_props

bind power_output_supervisor pos_props #(
  .WD_FAST_CYCLES(WD_FAST_CYCLES),
  .WD_SLOW_CYCLES(WD_SLOW_CYCLES)
) props_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .faults_i(faults_i), .cpu_irq_request_i(cpu_irq_request_i),
  .power_o(power_o), .power_mode_o(power_mode_o), .watchdog_osc_enable_o(watchdog_osc_enable_o),
  .main_regulator_on_o(main_regulator_on_o), .system_reset_o(system_reset_o), .irq_n_o(irq_n_o));

// >>> power_output_supervisor.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "power_output_supervisor_defs.svh"

module power_output_supervisor #(
  parameter int unsigned WD_FAST_CYCLES = `WD_FAST_CYC,
  parameter int unsigned WD_SLOW_CYCLES = `WD_SLOW_CYC
) (
  // Clock, reset and enable.
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // AXI4-Lite write address, data and response.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Analog fault and sensor inputs.
  input wire power_output_supervisor_pkg::fault_in_t faults_i,
  input wire logic chop_frequency_input_i,
  input wire logic [2:0] sensor_level_i,
  input wire logic cpu_irq_request_i,
  // Power controls and system lines.
  output power_output_supervisor_pkg::power_out_t power_o,
  output power_output_supervisor_pkg::slew_rate_t slew_rate_o,
  output power_output_supervisor_pkg::power_mode_t power_mode_o,
  output logic watchdog_osc_enable_o,
  output logic main_regulator_on_o,
  output logic system_reset_o,
  output logic irq_n_o
);
  import power_output_supervisor_pkg::*;

  initial begin
    if (WD_FAST_CYCLES < 2 || WD_SLOW_CYCLES < WD_FAST_CYCLES || WD_SLOW_CYCLES > 32'hffffff) begin
      $error("watchdog period parameters out of range");
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  assign s_axi_awready_o = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;

  wire aw_fire = s_axi_awvalid_i & s_axi_awready_o;
  wire w_fire = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire rd_go = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_lane0 = wr_go & wstrb_reg[0];
  wire [7:0] wbyte = wdata_reg[7:0];

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]) && (addr[1:0] == 2'b00);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, `OFS_INT_FLAGS) | hit(addr, `OFS_POWER_OUT) | hit(addr, `OFS_SYS_CTRL)
           | hit(addr, `OFS_WDOG_CTRL) | hit(addr, `OFS_SYS_STAT) | hit(addr, `OFS_SENSOR_CFG);
  endfunction : mapped

  // Offsets 0x01 and 0x03 do not share word 0 with 0x00; each is decoded as its own word index.
  function automatic logic [7:0] word_of(input logic [7:0] ofs);
    word_of = {ofs[5:0], 2'b00};
  endfunction : word_of

  wire wr_ifr = wr_lane0 && awaddr_reg == word_of(`OFS_INT_FLAGS);
  wire wr_pout = wr_lane0 && awaddr_reg == word_of(`OFS_POWER_OUT);
  wire wr_system_control = wr_lane0 && awaddr_reg == word_of(`OFS_SYS_CTRL);
  wire wr_wdctl = wr_lane0 && awaddr_reg == word_of(`OFS_WDOG_CTRL);
  wire wr_stat = wr_lane0 && awaddr_reg == word_of(`OFS_SYS_STAT);
  wire wr_scfg = wr_lane0 && awaddr_reg == word_of(`OFS_SENSOR_CFG);
  wire aw_mapped = awaddr_reg == word_of(`OFS_INT_FLAGS) || awaddr_reg == word_of(`OFS_POWER_OUT)
                || awaddr_reg == word_of(`OFS_SYS_CTRL) || awaddr_reg == word_of(`OFS_WDOG_CTRL)
                || awaddr_reg == word_of(`OFS_SYS_STAT) || awaddr_reg == word_of(`OFS_SENSOR_CFG);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic power_stage_enable_reg;
  logic [1:0] slew_select_reg;
  logic stop_request_reg;
  logic high_side_on_reg;
  logic switched_supply_on_reg;
  logic overtemp_reset_en_reg;
  logic low_voltage_flag_reg;
  logic high_voltage_flag_reg;
  logic overtemp_warning_flag_reg;
  logic high_side_overcurrent_flag_reg;
  logic high_side_drive_reg;
  logic switched_supply_overcurrent_flag_reg;
  logic sensor_pin_overcurrent_flag_reg;
  logic bridge_overcurrent_flag_reg;
  logic sensor_wake_flag_reg;
  logic [2:0] sensor_select_reg;
  logic sensor_irq_en_reg;
  logic watchdog_reset_enable_reg;
  logic watchdog_interrupt_enable_reg;
  logic cyclic_check_enable_reg;
  logic watchdog_timeout_flag_reg;
  logic watchdog_rate_select_reg;
  logic [23:0] wd_count_reg;
  logic chop_prev_reg;
  logic system_reset_reg;
  logic wake_reg;

  wire in_stop = stop_request_reg;
  wire chop_rise = chop_frequency_input_i & ~chop_prev_reg;
  wire wd_running = watchdog_interrupt_enable_reg | watchdog_reset_enable_reg
                  | cyclic_check_enable_reg; // [RL17]
  wire [23:0] wd_end = watchdog_rate_select_reg ? 24'(WD_FAST_CYCLES - 1)
                                                : 24'(WD_SLOW_CYCLES - 1); // [RL23]
  wire wd_hit = wd_running && wd_count_reg == wd_end;
  wire wd_restart = (wr_wdctl & wbyte[`BIT_WD_RESTART])
                  | (wr_wdctl & wbyte[`BIT_WD_FLAG]); // [RL20] [RL24]
  wire wd_count_en = wd_running & ~(in_stop & ~watchdog_interrupt_enable_reg
                                    & ~cyclic_check_enable_reg)
                   & ~(~in_stop & ~watchdog_reset_enable_reg & ~watchdog_interrupt_enable_reg); // [RL19]
  wire sensor_hit = |(sensor_level_i & sensor_select_reg);
  wire cyclic_wake = in_stop & cyclic_check_enable_reg & wd_hit
                   & sensor_hit & sensor_irq_en_reg; // [RL22]
  wire periodic_wake = in_stop & watchdog_interrupt_enable_reg & wd_hit; // [RL21]
  wire wd_reset_now = ~in_stop & watchdog_reset_enable_reg & wd_hit; // [RL19]
  wire ot_reset_now = overtemp_reset_en_reg & faults_i.overtemp_limit; // [RL3]
  wire irq_any = cpu_irq_request_i | periodic_wake | cyclic_wake;

  // Set wins over clear for every write-one-to-clear flag.
  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    w1c = set | (flag & ~clr); // [RL25]
  endfunction : w1c

  wire [7:0] ifr_read = {4'h0, sensor_wake_flag_reg, overtemp_warning_flag_reg,
                         high_voltage_flag_reg, low_voltage_flag_reg};
  wire [7:0] stat_read = {sensor_pin_overcurrent_flag_reg, faults_i.lin_current_limit, // [RL14]
                          switched_supply_overcurrent_flag_reg, high_side_overcurrent_flag_reg,
                          low_voltage_flag_reg, high_voltage_flag_reg, // [RL15]
                          bridge_overcurrent_flag_reg, overtemp_warning_flag_reg};
  wire [7:0] ctl_read = {power_stage_enable_reg, slew_select_reg, 5'h00}; // [RL10]
  wire [7:0] wd_read = {3'h0, watchdog_reset_enable_reg, watchdog_interrupt_enable_reg,
                        cyclic_check_enable_reg, watchdog_timeout_flag_reg,
                        watchdog_rate_select_reg};
  wire [7:0] pout_read = {5'h00, overtemp_reset_en_reg, switched_supply_on_reg, high_side_on_reg};
  wire [7:0] scfg_read = {4'h0, sensor_irq_en_reg, sensor_select_reg};
  wire [7:0] rd_byte = hit(s_axi_araddr_i, word_of(`OFS_INT_FLAGS)) ? ifr_read :
                       hit(s_axi_araddr_i, word_of(`OFS_POWER_OUT)) ? pout_read :
                       hit(s_axi_araddr_i, word_of(`OFS_SYS_CTRL)) ? ctl_read :
                       hit(s_axi_araddr_i, word_of(`OFS_WDOG_CTRL)) ? wd_read :
                       hit(s_axi_araddr_i, word_of(`OFS_SYS_STAT)) ? stat_read :
                       hit(s_axi_araddr_i, word_of(`OFS_SENSOR_CFG)) ? scfg_read : 8'h00;
  wire rd_mapped = hit(s_axi_araddr_i, word_of(`OFS_INT_FLAGS))
                 | hit(s_axi_araddr_i, word_of(`OFS_POWER_OUT))
                 | hit(s_axi_araddr_i, word_of(`OFS_SYS_CTRL))
                 | hit(s_axi_araddr_i, word_of(`OFS_WDOG_CTRL))
                 | hit(s_axi_araddr_i, word_of(`OFS_SYS_STAT))
                 | hit(s_axi_araddr_i, word_of(`OFS_SENSOR_CFG));

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= 32'h00000000;
    end else if (ce_i) begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= aw_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_mapped ? 2'b00 : 2'b10;
        rdata_reg <= {24'h000000, rd_byte};
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and fault flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power_stage_enable_reg <= 1'b0;
      slew_select_reg <= 2'b00;
      stop_request_reg <= 1'b0;
      high_side_on_reg <= 1'b0;
      switched_supply_on_reg <= 1'b0;
      overtemp_reset_en_reg <= 1'b0;
      sensor_select_reg <= 3'h0;
      sensor_irq_en_reg <= 1'b0;
      low_voltage_flag_reg <= 1'b0;
      high_voltage_flag_reg <= 1'b0;
      overtemp_warning_flag_reg <= 1'b0;
      sensor_wake_flag_reg <= 1'b0;
      high_side_overcurrent_flag_reg <= 1'b0;
      high_side_drive_reg <= 1'b1;
      switched_supply_overcurrent_flag_reg <= 1'b0;
      sensor_pin_overcurrent_flag_reg <= 1'b0;
      bridge_overcurrent_flag_reg <= 1'b0;
      chop_prev_reg <= 1'b0;
    end else if (ce_i) begin
      chop_prev_reg <= chop_frequency_input_i;
      if (wr_system_control) begin
        power_stage_enable_reg <= wbyte[`BIT_POWER_STAGE_ENABLE]; // [RL10]
        slew_select_reg <= wbyte[`BIT_SLEW_HI:`BIT_SLEW_LO];
      end
      if (irq_any) begin
        stop_request_reg <= 1'b0; // [RL12]
      end else if (wr_system_control && wbyte[`BIT_STOP]) begin
        stop_request_reg <= 1'b1; // [RL12]
      end
      if (wr_pout) begin
        high_side_on_reg <= wbyte[`BIT_HS_ON];
        switched_supply_on_reg <= wbyte[`BIT_SS_ON];
        overtemp_reset_en_reg <= wbyte[`BIT_OT_RST_EN];
      end
      if (wr_scfg) begin
        sensor_select_reg <= wbyte[2:0];
        sensor_irq_en_reg <= wbyte[3];
      end
      low_voltage_flag_reg <= w1c(low_voltage_flag_reg, faults_i.low_voltage,
                                  wr_ifr & wbyte[`BIT_IF_LV]); // [RL2]
      high_voltage_flag_reg <= w1c(high_voltage_flag_reg, faults_i.high_voltage,
                                   wr_ifr & wbyte[`BIT_IF_HV]); // [RL2]
      overtemp_warning_flag_reg <= w1c(overtemp_warning_flag_reg, faults_i.overtemp_warn,
                                       wr_ifr & wbyte[`BIT_IF_OT]); // [RL3]
      sensor_wake_flag_reg <= w1c(sensor_wake_flag_reg, cyclic_wake,
                                  wr_ifr & wbyte[`BIT_IF_SENSOR]);
      high_side_overcurrent_flag_reg <= w1c(high_side_overcurrent_flag_reg, faults_i.high_side_oc,
                                            wr_stat & wbyte[`BIT_ST_HSOC]); // [RL4] [RL6]
      if (faults_i.high_side_oc) begin
        high_side_drive_reg <= 1'b0; // [RL4]
      end else if (chop_rise || (wr_stat && wbyte[`BIT_ST_HSOC])) begin
        high_side_drive_reg <= 1'b1; // [RL5] [RL6]
      end
      switched_supply_overcurrent_flag_reg <= w1c(switched_supply_overcurrent_flag_reg,
                                                  faults_i.switched_supply_oc,
                                                  wr_stat & wbyte[`BIT_ST_SSOC]); // [RL9]
      sensor_pin_overcurrent_flag_reg <= w1c(sensor_pin_overcurrent_flag_reg,
                                             faults_i.sensor_pin_oc,
                                             wr_stat & wbyte[`BIT_ST_SENSOR]); // [RL13]
      bridge_overcurrent_flag_reg <= w1c(bridge_overcurrent_flag_reg, faults_i.bridge_oc,
                                         wr_stat & wbyte[`BIT_ST_HBOC]); // [RL16]
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      watchdog_reset_enable_reg <= 1'b0;
      watchdog_interrupt_enable_reg <= 1'b0;
      cyclic_check_enable_reg <= 1'b0;
      watchdog_timeout_flag_reg <= 1'b0;
      watchdog_rate_select_reg <= 1'b0; // [RL23]
      wd_count_reg <= 24'h000000;
      system_reset_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_wdctl) begin
        watchdog_reset_enable_reg <= watchdog_reset_enable_reg | wbyte[`BIT_WD_RE]; // [RL18]
        watchdog_interrupt_enable_reg <= wbyte[`BIT_WD_IE];
        cyclic_check_enable_reg <= wbyte[`BIT_WD_CC];
        watchdog_rate_select_reg <= wbyte[`BIT_WD_RATE];
      end
      watchdog_timeout_flag_reg <= w1c(watchdog_timeout_flag_reg, wd_hit & wd_count_en,
                                       wr_wdctl & wbyte[`BIT_WD_FLAG]); // [RL24]
      if (!wd_running || wd_restart || (wd_hit && wd_count_en)) begin
        wd_count_reg <= 24'h000000; // [RL20]
      end else if (wd_count_en) begin
        wd_count_reg <= wd_count_reg + 24'h000001;
      end
      system_reset_reg <= (wd_reset_now & wd_count_en) | ot_reset_now; // [RL19] [RL3]
      if (periodic_wake || cyclic_wake) begin
        wake_reg <= 1'b1; // [RL21] [RL22]
      end else if (!in_stop) begin
        wake_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire ot_kill = overtemp_reset_en_reg & faults_i.overtemp_limit; // [RL3] [RL8]

  always_comb begin
    power_o.high_side_output = power_stage_enable_reg & high_side_on_reg & high_side_drive_reg
                             & ~low_voltage_flag_reg & ~high_voltage_flag_reg & ~ot_kill; // [RL1]
    power_o.switched_supply_output = power_stage_enable_reg & switched_supply_on_reg
                                   & ~switched_supply_overcurrent_flag_reg & ~ot_kill; // [RL7] [RL9]
    power_o.bridges_enable = power_stage_enable_reg & ~bridge_overcurrent_flag_reg
                           & ~low_voltage_flag_reg & ~high_voltage_flag_reg & ~ot_kill; // [RL16]
    power_o.lin_tx_enable = power_stage_enable_reg & ~ot_kill;
    power_o.current_source_enable = power_stage_enable_reg & ~sensor_pin_overcurrent_flag_reg
                                  & ~ot_kill; // [RL13]
    power_o.sensor_power = in_stop & cyclic_check_enable_reg; // [RL22]
  end

  assign slew_rate_o = slew_rate_t'(slew_select_reg); // [RL11]
  assign power_mode_o = in_stop ? mode_stop : mode_run;
  assign watchdog_osc_enable_o = wd_running; // [RL17]
  assign main_regulator_on_o = ~in_stop | wake_reg;
  assign system_reset_o = system_reset_reg;
  assign irq_n_o = ~wake_reg;
endmodule : power_output_supervisor

// >>> power_output_supervisor_defs.svh
`ifndef POWER_OUTPUT_SUPERVISOR_DEFS_SVH
`define POWER_OUTPUT_SUPERVISOR_DEFS_SVH
// Overview of operation
// RL1: High-side output is forced off while low-voltage or high-voltage flag is set.
// RL2: Writing one or reset clears voltage flags; they set again while faults persist.
// RL3: Overtemp warning flag raised; enabled overtemp reset resets system, kills power outputs.
// RL4: High-side overcurrent switches the output off and sets its overcurrent flag.
// RL5: After high-side overcurrent, each chop input rising edge turns driver back on.
// RL6: Software judges real fault by persistent flag; writing one clears and re-enables.
// RL7: Switched supply is on only with power-stage enable and its on bit.
// RL8: Switched supply overtemp protection acts only when overtemp reset is enabled.
// RL9: Switched supply overcurrent turns it off and sets flag; write one clears.
// RL10: System control holds power enable bit 7, slew bits 6:5, stop bit 0.
// RL11: Slew code 00 initial, 01 slow, 10 high speed 8x, 11 high speed 4x.
// RL12: Writing stop request enters STOP; reset or interrupt request clears it.
// RL13: Sensor pin overcurrent sets its flag; writing one clears and re-enables.
// RL14: Status bit reports transmitter current limit; software should switch transmitter off.
// RL15: Status voltage and overtemp bits mirror the interrupt flag register bits.
// RL16: Bridge overcurrent sets its flag; writing one clears and re-enables bridge drivers.
// RL17: Watchdog runs only while interrupt, reset or cyclic check enable is set.
// RL18: Watchdog reset enable, once set, cannot be cleared by software before reset.
// RL19: Timeout with reset enable resets system; counting pauses in STOP mode (code: only while interrupt and cyclic check enables are clear).
// RL20: Software writes restart bit before timeout; each write restarts the period.
// RL21: In STOP with watchdog interrupt enable, the device wakes after selected period.
// RL22: In STOP with cyclic check, sampled sensor one with interrupt enable wakes system.
// RL23: Rate bit set selects 10 ms, clear selects 20 ms; reset clears it.
// RL24: Timeout flag sets on timeout; writing one clears it and restarts counter.
// RL25: A fault in the same cycle as a clearing write keeps the flag set.

`define OFS_INT_FLAGS 8'h00
`define OFS_POWER_OUT 8'h01
`define OFS_SYS_CTRL 8'h03
`define OFS_WDOG_CTRL 8'h0a
`define OFS_SYS_STAT 8'h0c
`define OFS_SENSOR_CFG 8'h10

`define BIT_POWER_STAGE_ENABLE 7
`define BIT_SLEW_HI 6
`define BIT_SLEW_LO 5
`define BIT_STOP 0
`define BIT_HS_ON 0
`define BIT_SS_ON 1
`define BIT_OT_RST_EN 2
`define BIT_ST_SENSOR 7
`define BIT_ST_TRANSMITTER_CURRENT_LIMIT_FLAG 6
`define BIT_ST_SSOC 5
`define BIT_ST_HSOC 4
`define BIT_ST_LV 3
`define BIT_ST_HV 2
`define BIT_ST_HBOC 1
`define BIT_ST_OT 0
`define BIT_IF_LV 0
`define BIT_IF_HV 1
`define BIT_IF_OT 2
`define BIT_IF_SENSOR 3
`define BIT_WD_RESTART 5
`define BIT_WD_RE 4
`define BIT_WD_IE 3
`define BIT_WD_CC 2
`define BIT_WD_FLAG 1
`define BIT_WD_RATE 0

`define RST_SYS_CTRL 8'h00
`define RST_WDOG_CTRL 8'h00
`define CLK_HZ 20000000
`define WD_FAST_MS 10
`define WD_SLOW_MS 20
`define WD_FAST_CYC ((`CLK_HZ / 1000) * `WD_FAST_MS)
`define WD_SLOW_CYC ((`CLK_HZ / 1000) * `WD_SLOW_MS)
`endif

// >>> power_output_supervisor_pkg.sv
package power_output_supervisor_pkg;
  typedef enum logic [1:0] {
    slew_initial,
    slew_slow,
    slew_fast_8x,
    slew_fast_4x
  } slew_rate_t;

  typedef enum logic {
    mode_run,
    mode_stop
  } power_mode_t;

  typedef struct packed {
    logic low_voltage;
    logic high_voltage;
    logic overtemp_warn;
    logic overtemp_limit;
    logic high_side_oc;
    logic switched_supply_oc;
    logic sensor_pin_oc;
    logic bridge_oc;
    logic lin_current_limit;
  } fault_in_t;

  typedef struct packed {
    logic high_side_output;
    logic switched_supply_output;
    logic bridges_enable;
    logic lin_tx_enable;
    logic current_source_enable;
    logic sensor_power;
  } power_out_t;
endpackage : power_output_supervisor_pkg

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import power_output_supervisor_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] aw = '0, ar = '0;
  logic [31:0] wd = '0;
  logic [31:0] rdat;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic awr, wrd, bv, arr, rv, osc, reg_on, sysrst, irq_n, irq_req;
  logic [1:0] br, rr;
  logic [8:0] flt = '0;
  logic chop = 1'b0, ce = 1'b1;
  logic sr_seen = 1'b0;
  logic [2:0] sens = '0;
  power_out_t pw;
  slew_rate_t slew;
  power_mode_t mode;
  int n_fail = 0;
  int checks_done = 0;
  int fb[3] = '{3, 2, 1};
  int sb[3] = '{5, 7, 1};
  logic [5:0] okm[3] = '{6'h10, 6'h02, 6'h08};
  power_output_supervisor #(.WD_FAST_CYCLES(20), .WD_SLOW_CYCLES(40)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1),
    .faults_i(fault_in_t'(flt)), .chop_frequency_input_i(chop), .sensor_level_i(sens),
    .cpu_irq_request_i(irq_req), .power_o(pw), .slew_rate_o(slew), .power_mode_o(mode),
    .watchdog_osc_enable_o(osc), .main_regulator_on_o(reg_on), .system_reset_o(sysrst),
    .irq_n_o(irq_n));
  mcu_model mcu_u (.mclk_i(mclk_i), .irq_n_i(irq_n), .irq_req_o(irq_req));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) sr_seen <= !rst_i && (sr_seen || sysrst === 1'b1);
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  task automatic bound(input int n);
    if (n >= 50) begin
      n_fail++;
      wrap_up();
    end
  endtask : bound
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      n++;
    end while (!bv && n < 50);
    bound(n);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n = 0;
    ar <= a;
    arv <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 50);
    bound(n);
    chk(rdat, e);
  endtask : rd
  task automatic do_reset();
    rst_i <= 1'b1;
    tick(6);
    rst_i <= 1'b0;
    tick(1);
  endtask : do_reset
  initial begin
    #200us;
    n_fail++;
    wrap_up();
  end
  initial begin
    int n;
    logic [31:0] v;
    void'($urandom(48));
    do_reset();
    rd(8'h0c, 32'h0);
    rd(8'h3c, 32'h0);
    chk(rr, 2'b10);
    wr(8'h3c, 32'hff);
    chk(br, 2'b10);
    for (int c = 0; c < 4; c++) begin
      v = {24'h0, 1'b1, c[1:0], 5'h0};
      wr(8'h0c, v | ($urandom & 32'hffffff1e));
      chk(slew, c[1:0]);
      rd(8'h0c, v);
    end
    wr(8'h04, 32'h3);
    chk(pw[5:4], 2'b11);
    flt[8] <= 1'b1;
    tick(3);
    chk(pw[5:4], 2'b01);
    rd(8'h30, 32'h08);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    flt[8] <= 1'b0;
    tick(2);
    wr(8'h00, 32'h1);
    chk(pw[5], 1'b1);
    flt[4] <= 1'b1;
    tick(2);
    flt[4] <= 1'b0;
    tick(2);
    chk(pw[5], 1'b0);
    ce <= 1'b0;
    chop <= 1'b1;
    tick(3);
    chk(pw[5], 1'b0);
    ce <= 1'b1;
    tick(3);
    chk(pw[5], 1'b1);
    chop <= 1'b0;
    wr(8'h30, 32'h0);
    rd(8'h30, 32'h10);
    wr(8'h30, 32'h10);
    rd(8'h30, 32'h0);
    for (int i = 0; i < 3; i++) begin
      flt[fb[i]] <= 1'b1;
      tick(2);
      wr(8'h30, 32'h1 << sb[i]);
      rd(8'h30, 32'h1 << sb[i]);
      flt[fb[i]] <= 1'b0;
      tick(2);
      chk(pw & okm[i], 6'h0);
      wr(8'h30, 32'h0);
      rd(8'h30, 32'h1 << sb[i]);
      wr(8'h30, 32'h1 << sb[i]);
      rd(8'h30, 32'h0);
      chk(pw & okm[i], okm[i]);
    end
    flt[0] <= 1'b1;
    tick(2);
    wr(8'h30, 32'h40);
    rd(8'h30, 32'h40);
    flt[6:0] <= 7'h60;
    tick(2);
    rd(8'h00, 32'h4);
    wr(8'h04, 32'h7);
    for (n = 0; n < 40 && sysrst !== 1'b1; n++) tick(1);
    chk(n < 40, 1'b1);
    chk(pw, 6'h0);
    flt <= '0;
    do_reset();
    wr(8'h28, 32'h10);
    chk(osc, 1'b1);
    repeat (3) begin
      tick(25);
      wr(8'h28, 32'h30);
    end
    chk(sr_seen, 1'b0);
    wr(8'h28, 32'h0);
    rd(8'h28, 32'h10);
    for (n = 0; n < 80 && sysrst !== 1'b1; n++) tick(1);
    chk(n < 80, 1'b1);
    for (int i = 0; i < 2; i++) begin
      do_reset();
      sens <= 3'b001;
      wr(8'h40, i ? 32'h9 : 32'h0);
      wr(8'h28, i ? 32'h4 : 32'h9);
      wr(8'h0c, 32'h1);
      chk(mode, mode_stop);
      for (n = 0; n < 60 && irq_n !== 1'b0; n++) tick(1);
      chk(n < (i ? 60 : 24), 1'b1);
      chk(reg_on, 1'b1);
      tick(3);
      chk(mode, mode_run);
    end
    wrap_up();
  end
endmodule : testbench
